// File: rtl/dsr_dev.sv
// Flash end: instruction front end on the link clock, mode and timers on sys_clk_i.
// Assumes rst_n_i is the power-on reset and the host holds select high between frames.
// Summary of operation
// - Deep sleep accepts only wake-and-signature read
// - Wake-and-signature read ends deep sleep
// - Signature returned whenever no write cycle runs
// - Wake instruction ignored during busy cycles
// - Opcode plus three dummy bytes, rising edge
// - Signature out MSB first on falling edge
// - Signature repeats while clocks continue
// - Host deselects after the requested read bytes
// - Standby at once when not sleeping
// - From deep sleep, standby after wake delay
// - Early deselect after opcode still wakes
// - Power-on reset holds all logic idle
// - Write instructions ignored until unlock delay
// - Host defers writes past both power delays
// - Reads served once select delay passes
// - Powers up standby, write arm cleared
// - Array reads FFh, status reads 00h
// - Deep sleep entry rejected while busy
// - Busy flag high during self-timed cycle
`timescale 1ns/1ps
module dsr_dev #(
  parameter logic [7:0] SIG_CODE    = 8'hA5,  // Arbitrary value
  parameter int         PUW_CYC     = dsr_pkg::PUW_MIN_CYC,
  parameter int         WAKE_CYC    = dsr_pkg::WAKE_MAX_CYC,
  parameter int         BUSY_LEN    = dsr_pkg::BUSY_CYC
) (
  input  wire logic     sys_clk_i,
  input  wire logic     rst_n_i,
  dsr_link_if.dev       link,
  output logic          deep_sleep_o,
  output logic          busy_o,
  output logic          write_arm_o,
  output logic          write_unlocked_o
);
  // Link domain
  logic        frame_rst_n;
  logic        started_ff;
  logic [5:0]  cnt_ff;
  logic [5:0]  nxt_cnt;
  logic [7:0]  op_ff;
  logic [7:0]  nxt_op;
  logic        long_ff;
  logic        nxt_long;
  logic        accept_ff;
  logic        nxt_accept;
  logic        tgl_ff;
  logic        nxt_tgl;
  logic [2:0]  ms1_ff;
  logic [2:0]  ms2_ff;
  logic        so_ff;
  logic        nxt_so;
  logic        oe_ff;
  logic        nxt_oe;
  logic [7:0]  out_byte;
  logic [5:0]  out_start;
  logic [5:0]  cnt_b;
  logic        sleep_l;
  logic        busy_l;

  // Sys domain
  dsr_pkg::dsr_mode_t mode_ff;
  dsr_pkg::dsr_mode_t nxt_mode;
  logic        cs1_ff;
  logic        cs2_ff;
  logic        cs3_ff;
  logic        tg1_ff;
  logic        tg2_ff;
  logic        seen_ff;
  logic        nxt_seen;
  logic        arm_ff;
  logic        nxt_arm;
  logic [23:0] busy_cnt_ff;
  logic [23:0] nxt_busy_cnt;
  logic [23:0] wake_cnt_ff;
  logic [23:0] nxt_wake_cnt;
  logic [23:0] puw_cnt_ff;
  logic [23:0] nxt_puw_cnt;
  logic        unlocked;
  logic        busy;
  logic        cs_rise;

  assign frame_rst_n = rst_n_i & ~link.cs_n;
  assign sleep_l     = ms2_ff[2];
  assign busy_l      = ms2_ff[1];

  // A frame restarts its counters on its own first edge
  always_ff @(posedge link.sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      started_ff <= 1'b0;
    end else begin
      started_ff <= 1'b1;
    end
  end

  always_comb begin
    cnt_b      = started_ff ? cnt_ff : 6'h00;
    nxt_tgl    = started_ff ? tgl_ff : ~tgl_ff;
    nxt_op     = (cnt_b < dsr_pkg::CNT_OPCODE) ? {op_ff[6:0], link.mosi} : op_ff;
    nxt_cnt    = (cnt_b == dsr_pkg::CNT_DATA_LAST) ? dsr_pkg::CNT_DATA : cnt_b + 6'h01;
    nxt_long   = (started_ff & long_ff) | (cnt_b == dsr_pkg::CNT_DATA_LAST);
    nxt_accept = started_ff & accept_ff;
    if (cnt_b == dsr_pkg::CNT_OPCODE - 6'h01) begin
      if (sleep_l) begin
        nxt_accept = (nxt_op == dsr_pkg::OP_WAKE_SIG);
      end else if (busy_l) begin
        nxt_accept = (nxt_op == dsr_pkg::OP_READ_STAT);
      end else begin
        nxt_accept = 1'b1;
      end
    end
  end

  always_ff @(posedge link.sck or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff    <= 6'h00;
      op_ff     <= 8'h00;
      long_ff   <= 1'b0;
      accept_ff <= 1'b0;
      tgl_ff    <= 1'b0;
      ms1_ff    <= 3'h0;
      ms2_ff    <= 3'h0;
    end else begin
      cnt_ff    <= nxt_cnt;
      op_ff     <= nxt_op;
      long_ff   <= nxt_long;
      accept_ff <= nxt_accept;
      tgl_ff    <= nxt_tgl;
      ms1_ff    <= {mode_ff != dsr_pkg::DSR_STANDBY, busy, arm_ff};
      ms2_ff    <= ms1_ff;
    end
  end

  // Output byte and where it starts
  always_comb begin
    out_start = dsr_pkg::CNT_DATA;
    unique case (op_ff)
      dsr_pkg::OP_WAKE_SIG:  out_byte = SIG_CODE;
      dsr_pkg::OP_READ_DATA: out_byte = dsr_pkg::ERASED_BYTE;
      dsr_pkg::OP_READ_STAT: begin
        out_byte  = {dsr_pkg::STAT_PAD_RST, ms2_ff[0], busy_l};
        out_start = dsr_pkg::CNT_OPCODE;
      end
      default:               out_byte = 8'h00;
    endcase
    nxt_oe = 1'b0;
    nxt_so = 1'b0;
    if (accept_ff && cnt_ff >= out_start && (op_ff == dsr_pkg::OP_WAKE_SIG ||
        op_ff == dsr_pkg::OP_READ_DATA || op_ff == dsr_pkg::OP_READ_STAT)) begin
      nxt_oe = 1'b1;
      nxt_so = out_byte[~cnt_ff[2:0]];
    end
  end

  always_ff @(negedge link.sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      so_ff <= nxt_so;
      oe_ff <= nxt_oe;
    end
  end

  assign link.miso    = so_ff;
  assign link.miso_oe = oe_ff;

  // Sys domain: frame end detection and execution
  assign cs_rise  = cs2_ff & ~cs3_ff;
  assign busy     = (busy_cnt_ff != 24'h0000);
  assign unlocked = (puw_cnt_ff == 24'(PUW_CYC));

  always_comb begin
    nxt_mode     = mode_ff;
    nxt_arm      = arm_ff;
    nxt_seen     = seen_ff;
    nxt_busy_cnt = busy ? busy_cnt_ff - 24'h0001 : busy_cnt_ff;
    nxt_wake_cnt = wake_cnt_ff;
    nxt_puw_cnt  = unlocked ? puw_cnt_ff : puw_cnt_ff + 24'h0001;
    if (busy_cnt_ff == 24'h0001) begin
      nxt_arm = 1'b0;
    end
    if (mode_ff == dsr_pkg::DSR_WAKING) begin
      nxt_wake_cnt = wake_cnt_ff - 24'h0001;
      if (wake_cnt_ff == 24'h0001) begin
        nxt_mode = dsr_pkg::DSR_STANDBY;
      end
    end
    if (cs_rise && tg2_ff != seen_ff) begin
      nxt_seen = tg2_ff;
      if (accept_ff && cnt_ff >= dsr_pkg::CNT_OPCODE) begin
        if (op_ff == dsr_pkg::OP_WAKE_SIG && !busy) begin
          if (mode_ff == dsr_pkg::DSR_DEEP) begin
            nxt_mode     = dsr_pkg::DSR_WAKING;
            nxt_wake_cnt = 24'(WAKE_CYC);
          end
        end else if (mode_ff == dsr_pkg::DSR_STANDBY && !busy) begin
          if (op_ff == dsr_pkg::OP_DEEP_SLEEP && cnt_ff == dsr_pkg::CNT_OPCODE
              && !long_ff) begin
            nxt_mode = dsr_pkg::DSR_DEEP;
          end else if (unlocked && dsr_pkg::dsr_is_write(op_ff)) begin
            if (op_ff == dsr_pkg::OP_WRITE_ARM && cnt_ff == dsr_pkg::CNT_OPCODE
                && !long_ff) begin
              nxt_arm = 1'b1;
            end else if (arm_ff && !long_ff &&
                ((op_ff == dsr_pkg::OP_FULL_WIPE && cnt_ff == dsr_pkg::CNT_OPCODE) ||
                 (op_ff == dsr_pkg::OP_CFG_WRITE && cnt_ff == dsr_pkg::CNT_CFG) ||
                 (op_ff == dsr_pkg::OP_BLOCK_WIPE && cnt_ff == dsr_pkg::CNT_DATA))) begin
              nxt_busy_cnt = 24'(BUSY_LEN);
            end else if (arm_ff && long_ff && op_ff == dsr_pkg::OP_PAGE_WRITE
                && cnt_ff == dsr_pkg::CNT_DATA) begin
              nxt_busy_cnt = 24'(BUSY_LEN);
            end
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ff     <= dsr_pkg::DSR_STANDBY;
      arm_ff      <= 1'b0;
      cs1_ff      <= 1'b1;
      cs2_ff      <= 1'b1;
      cs3_ff      <= 1'b1;
      tg1_ff      <= 1'b0;
      tg2_ff      <= 1'b0;
      seen_ff     <= 1'b0;
      busy_cnt_ff <= 24'h0000;
      wake_cnt_ff <= 24'h0000;
      puw_cnt_ff  <= 24'h0000;
    end else begin
      mode_ff     <= nxt_mode;
      arm_ff      <= nxt_arm;
      cs1_ff      <= link.cs_n;
      cs2_ff      <= cs1_ff;
      cs3_ff      <= cs2_ff;
      tg1_ff      <= tgl_ff;
      tg2_ff      <= tg1_ff;
      seen_ff     <= nxt_seen;
      busy_cnt_ff <= nxt_busy_cnt;
      wake_cnt_ff <= nxt_wake_cnt;
      puw_cnt_ff  <= nxt_puw_cnt;
    end
  end

  assign deep_sleep_o     = (mode_ff != dsr_pkg::DSR_STANDBY);
  assign busy_o           = busy;
  assign write_arm_o      = arm_ff;
  assign write_unlocked_o = unlocked;
endmodule : dsr_dev

// File: rtl/dsr_pkg.sv
// Shared constants and types for the deep sleep release and signature link.
// Assumes a 100 MHz system clock on both ends and an SPI mode 0 link.
package dsr_pkg;
  localparam int CLK_MHZ      = 100;
  // Write unlock delay after reset release, least and most, in ms
  localparam int PUW_MIN_MS   = 1;
  localparam int PUW_MAX_MS   = 10;
  localparam int PUW_MIN_CYC  = PUW_MIN_MS * 1000 * CLK_MHZ;
  localparam int PUW_MAX_CYC  = PUW_MAX_MS * 1000 * CLK_MHZ;
  // Select after supply delay, least, in us
  localparam int VSL_US       = 10;
  localparam int VSL_CYC      = VSL_US * CLK_MHZ;
  // Wake delay, most, in us
  localparam int WAKE_MAX_US  = 30;
  localparam int WAKE_MAX_CYC = WAKE_MAX_US * CLK_MHZ;
  // Self-timed write cycle length
  localparam int BUSY_CYC     = 2000;
  // Host deselect gap and link half period, in system cycles
  localparam int DESEL_CYC    = 8;
  localparam int SCK_HALF     = 4;

  localparam logic [7:0] OP_WAKE_SIG   = 8'hAB;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WRITE_ARM  = 8'h06;
  localparam logic [7:0] OP_CFG_WRITE  = 8'h01;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_BLOCK_WIPE = 8'hD8;
  localparam logic [7:0] OP_FULL_WIPE  = 8'hC7;
  localparam logic [7:0] OP_READ_DATA  = 8'h03;
  localparam logic [7:0] OP_READ_STAT  = 8'h05;

  localparam logic [7:0] ERASED_BYTE   = 8'hFF;
  localparam logic [5:0] STAT_PAD_RST  = 6'h00;
  localparam logic [5:0] CNT_OPCODE    = 6'h08;
  localparam logic [5:0] CNT_CFG       = 6'h10;
  localparam logic [5:0] CNT_DATA      = 6'h20;
  localparam logic [5:0] CNT_DATA_LAST = 6'h27;

  typedef enum logic [1:0] {DSR_STANDBY, DSR_DEEP, DSR_WAKING} dsr_mode_t;
  typedef enum logic [1:0] {DSR_H_IDLE, DSR_H_SHIFT, DSR_H_GAP} dsr_host_st_t;

  // Instructions gated by the write unlock delay; all but write arm also need the write arm flag
  function automatic logic dsr_is_write(input logic [7:0] op);
    dsr_is_write = (op == OP_WRITE_ARM) || (op == OP_CFG_WRITE) ||
                   (op == OP_PAGE_WRITE) || (op == OP_BLOCK_WIPE) ||
                   (op == OP_FULL_WIPE);
  endfunction : dsr_is_write
endpackage : dsr_pkg

// File: rtl/dsr_link_if.sv
// SPI link between the host end and the flash end.
// Assumes the bench resolves the data-out wire from miso_oe.
`timescale 1ns/1ps
interface dsr_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport dev (
    input  cs_n,
    input  sck,
    input  mosi,
    output miso,
    output miso_oe
  );
  modport host (
    output cs_n,
    output sck,
    output mosi,
    input  miso,
    input  miso_oe
  );
endinterface : dsr_link_if

// File: rtl/dsr_host.sv
// Host end: drives select, clock and data; clock divided from sys_clk_i.
// Assumes one request at a time; read bytes come back as one-cycle pulses.
`timescale 1ns/1ps
module dsr_host #(
  parameter int VSL_LEN  = dsr_pkg::VSL_CYC,
  parameter int PUW_LEN  = dsr_pkg::PUW_MAX_CYC,
  parameter int WAKE_LEN = dsr_pkg::WAKE_MAX_CYC,
  parameter int HALF     = dsr_pkg::SCK_HALF
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  dsr_link_if.host         link,
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic [7:0]  req_op_i,
  input  wire logic [23:0] req_arg_i,
  input  wire logic [1:0]  req_arg_bytes_i,
  input  wire logic [7:0]  req_rd_bytes_i,
  output logic             rsp_valid_o,
  output logic [7:0]       rsp_data_o
);
  dsr_pkg::dsr_host_st_t st_ff;
  dsr_pkg::dsr_host_st_t nxt_st;
  logic [7:0]  div_ff;
  logic [7:0]  nxt_div;
  logic        sck_ff;
  logic        nxt_sck;
  logic        cs_n_ff;
  logic        nxt_cs_n;
  logic [31:0] tx_ff;
  logic [31:0] nxt_tx;
  logic [7:0]  rx_ff;
  logic [7:0]  nxt_rx;
  logic [11:0] bit_ff;
  logic [11:0] nxt_bit;
  logic [11:0] total_ff;
  logic [11:0] nxt_total;
  logic [11:0] rd_at_ff;
  logic [11:0] nxt_rd_at;
  logic [23:0] gap_ff;
  logic [23:0] nxt_gap;
  logic [23:0] up_ff;
  logic [23:0] nxt_up;
  logic        rv_ff;
  logic        nxt_rv;
  logic [7:0]  rd_ff;
  logic [7:0]  nxt_rd;
  logic        so1_ff;
  logic        so2_ff;

  function automatic logic [11:0] dsr_bits(input logic [11:0] nbytes);
    dsr_bits = {nbytes[8:0], 3'h0};
  endfunction : dsr_bits

  assign req_ready_o = (st_ff == dsr_pkg::DSR_H_IDLE) && (up_ff >= 24'(VSL_LEN)) &&
                       (!dsr_pkg::dsr_is_write(req_op_i) || up_ff == 24'(PUW_LEN));

  always_comb begin
    nxt_st    = st_ff;
    nxt_div   = div_ff;
    nxt_sck   = sck_ff;
    nxt_cs_n  = cs_n_ff;
    nxt_tx    = tx_ff;
    nxt_rx    = rx_ff;
    nxt_bit   = bit_ff;
    nxt_total = total_ff;
    nxt_rd_at = rd_at_ff;
    nxt_gap   = gap_ff;
    nxt_up    = (up_ff == 24'(PUW_LEN)) ? up_ff : up_ff + 24'h0001;
    nxt_rv    = 1'b0;
    nxt_rd    = rd_ff;
    unique case (st_ff)
      dsr_pkg::DSR_H_IDLE: begin
        if (req_valid_i && req_ready_o) begin
          nxt_st    = dsr_pkg::DSR_H_SHIFT;
          nxt_cs_n  = 1'b0;
          nxt_div   = 8'h00;
          nxt_bit   = 12'h000;
          nxt_tx    = {req_op_i, req_arg_i};
          nxt_rd_at = dsr_bits({10'h000, req_arg_bytes_i} + 12'h001);
          nxt_total = dsr_bits({4'h0, req_rd_bytes_i} + {10'h000, req_arg_bytes_i} + 12'h001);
          nxt_gap   = (req_op_i == dsr_pkg::OP_WAKE_SIG) ? 24'(WAKE_LEN)
                                                          : 24'(dsr_pkg::DESEL_CYC);
        end
      end
      dsr_pkg::DSR_H_SHIFT: begin
        nxt_div = div_ff + 8'h01;
        if (div_ff == 8'(HALF - 1)) begin
          nxt_div = 8'h00;
          if (!sck_ff) begin
            nxt_sck = 1'b1;
            nxt_rx  = {rx_ff[6:0], so2_ff};
            nxt_bit = bit_ff + 12'h001;
            if (nxt_bit > rd_at_ff && nxt_bit[2:0] == 3'h0) begin
              nxt_rv = 1'b1;
              nxt_rd = nxt_rx;
            end
          end else if (bit_ff == total_ff) begin
            nxt_sck  = 1'b0;
            nxt_cs_n = 1'b1;
            nxt_st   = dsr_pkg::DSR_H_GAP;
          end else begin
            nxt_sck = 1'b0;
            nxt_tx  = {tx_ff[30:0], 1'b0};
          end
        end
      end
      dsr_pkg::DSR_H_GAP: begin
        nxt_gap = gap_ff - 24'h0001;
        if (gap_ff <= 24'h0001) begin
          nxt_st = dsr_pkg::DSR_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff    <= dsr_pkg::DSR_H_IDLE;
      div_ff   <= 8'h00;
      sck_ff   <= 1'b0;
      cs_n_ff  <= 1'b1;
      tx_ff    <= 32'h0000_0000;
      rx_ff    <= 8'h00;
      bit_ff   <= 12'h000;
      total_ff <= 12'h000;
      rd_at_ff <= 12'h000;
      gap_ff   <= 24'h0000;
      up_ff    <= 24'h0000;
      rv_ff    <= 1'b0;
      rd_ff    <= 8'h00;
      so1_ff   <= 1'b0;
      so2_ff   <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      div_ff   <= nxt_div;
      sck_ff   <= nxt_sck;
      cs_n_ff  <= nxt_cs_n;
      tx_ff    <= nxt_tx;
      rx_ff    <= nxt_rx;
      bit_ff   <= nxt_bit;
      total_ff <= nxt_total;
      rd_at_ff <= nxt_rd_at;
      gap_ff   <= nxt_gap;
      up_ff    <= nxt_up;
      rv_ff    <= nxt_rv;
      rd_ff    <= nxt_rd;
      so1_ff   <= link.miso;
      so2_ff   <= so1_ff;
    end
  end

  assign link.cs_n   = cs_n_ff;
  assign link.sck    = sck_ff;
  assign link.mosi   = tx_ff[31];
  assign rsp_valid_o = rv_ff;
  assign rsp_data_o  = rd_ff;
endmodule : dsr_host

// File: testbench/dsr_link_chk_sva.sv
// Checker on the link between host end and flash end.
// Assumes instantiation beside the link interface, parameters matching the flash end.
`timescale 1ns/1ps
module dsr_link_chk #(
  parameter int         PUW_CYC  = dsr_pkg::PUW_MIN_CYC,
  parameter int         BUSY_LEN = dsr_pkg::BUSY_CYC,
  parameter logic [7:0] SIG_CODE = 8'hA5  // Arbitrary value
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic deep_sleep_o,
  input wire logic busy_o,
  input wire logic write_arm_o,
  input wire logic write_unlocked_o
);
  logic [23:0] up_ff;
  logic [23:0] nxt_up;
  logic [23:0] brun_ff;
  logic [23:0] nxt_brun;
  logic [5:0]  bit_ff;
  logic [5:0]  nxt_bit;
  logic [7:0]  op_ff;
  logic [7:0]  nxt_op;

  // Cycles since reset release, busy run length, rises and opcode in a frame
  always_comb begin
    nxt_up   = (up_ff == 24'hFF_FFFF) ? up_ff : up_ff + 24'h00_0001;
    nxt_brun = busy_o ? brun_ff + 24'h00_0001 : 24'h00_0000;
    nxt_bit = (bit_ff == 6'h3F) ? bit_ff : bit_ff + 6'h01;
    nxt_op  = (bit_ff < 6'h08) ? {op_ff[6:0], mosi} : op_ff;
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_ff   <= 24'h00_0000;
      brun_ff <= 24'h00_0000;
    end else begin
      up_ff   <= nxt_up;
      brun_ff <= nxt_brun;
    end
  end
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_ff <= 6'h00;
      op_ff  <= 8'h00;
    end else begin
      bit_ff <= nxt_bit;
      op_ff  <= nxt_op;
    end
  end

  sequence s_sleep_deselect;
    deep_sleep_o ##0 $rose(cs_n);
  endsequence
  sequence s_busy_run;
    busy_o [*8];
  endsequence

  a_reset_state: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) == 1'b0 |-> !deep_sleep_o && !busy_o && !write_arm_o && !write_unlocked_o)
    else $error("state not idle after reset");
  a_unlock_wait: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    up_ff < 24'(PUW_CYC) |-> !write_unlocked_o) else $error("write unlock too early");
  a_arm_gated: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(write_arm_o) |-> write_unlocked_o) else $error("arm flag set while locked");
  a_oe_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cs_n |-> !miso_oe) else $error("data out driven while deselected");
  a_no_deep_busy: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(deep_sleep_o) |-> !$past(busy_o)) else $error("deep sleep entered while busy");
  a_busy_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(busy_o) |-> s_busy_run) else $error("busy ended too soon");
  a_busy_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(busy_o) |-> brun_ff == 24'(BUSY_LEN)) else $error("busy length wrong");
  a_arm_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(busy_o) |-> ##[0:2] !write_arm_o) else $error("arm flag kept after busy");
  a_wake_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_sleep_deselect |-> deep_sleep_o [*8]) else $error("wake delay skipped");
  a_out_start: assert property (@(posedge sck) disable iff (!rst_n_i || cs_n)
    $rose(miso_oe) |-> (op_ff == dsr_pkg::OP_READ_STAT) ? (bit_ff == 6'h08) : (bit_ff == 6'h20))
    else $error("output started at wrong bit");
  a_sig_bits: assert property (@(posedge sck) disable iff (!rst_n_i || cs_n)
    miso_oe && op_ff == dsr_pkg::OP_WAKE_SIG && bit_ff >= 6'h20 |->
    miso == SIG_CODE[3'd7 - bit_ff[2:0]]) else $error("signature bit wrong");
  a_deep_ignores: assert property (@(posedge sck) disable iff (!rst_n_i || cs_n)
    $rose(miso_oe) && deep_sleep_o |-> op_ff == dsr_pkg::OP_WAKE_SIG)
    else $error("answer given in deep sleep");
  a_busy_quiet: assert property (@(posedge sck) disable iff (!rst_n_i || cs_n)
    $rose(miso_oe) && busy_o |-> op_ff == dsr_pkg::OP_READ_STAT)
    else $error("answer given while busy");
endmodule : dsr_link_chk

// File: testbench/deep_sleep_release_signature_bench.sv
// Bench joining host end and flash end over the link interface.
// Assumes shortened delays; host makes the link clock from sys_clk_i.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
  miscompares++; $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module deep_sleep_release_signature_bench;
  localparam int         DEV_PUW  = 200;
  localparam int         DEV_WAKE = 50;
  localparam int         DEV_BUSY = 1500;
  localparam logic [7:0] SIG      = 8'h3C;  // Arbitrary value
  logic        sys_clk_i;
  logic        rst_n_i;
  logic        req_valid;
  logic        req_ready;
  logic [7:0]  req_op;
  logic [23:0] req_arg;
  logic [1:0]  req_nargs;
  logic [7:0]  req_nrd;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic        deep_sleep;
  logic        busy;
  logic        write_arm;
  logic        write_unlocked;
  logic        oe_seen;
  logic [7:0]  rd_q [8];
  int          miscompares;
  int          samples_checked;
  int          cyc;
  int          n;
  int          unlock_cyc;

  dsr_link_if dsr_link_if_inst ();
  dsr_dev #(.SIG_CODE(SIG), .PUW_CYC(DEV_PUW), .WAKE_CYC(DEV_WAKE), .BUSY_LEN(DEV_BUSY))
  dsr_dev_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link(dsr_link_if_inst.dev),
    .deep_sleep_o(deep_sleep), .busy_o(busy), .write_arm_o(write_arm),
    .write_unlocked_o(write_unlocked));
  dsr_host #(.VSL_LEN(20), .PUW_LEN(250), .WAKE_LEN(80), .HALF(4))
  dsr_host_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link(dsr_link_if_inst.host),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_op_i(req_op), .req_arg_i(req_arg),
    .req_arg_bytes_i(req_nargs), .req_rd_bytes_i(req_nrd), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data));
  dsr_link_chk #(.PUW_CYC(DEV_PUW), .BUSY_LEN(DEV_BUSY), .SIG_CODE(SIG))
  dsr_link_chk_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cs_n(dsr_link_if_inst.cs_n),
    .sck(dsr_link_if_inst.sck), .mosi(dsr_link_if_inst.mosi), .miso(dsr_link_if_inst.miso),
    .miso_oe(dsr_link_if_inst.miso_oe), .deep_sleep_o(deep_sleep), .busy_o(busy),
    .write_arm_o(write_arm), .write_unlocked_o(write_unlocked));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cyc <= 0;
    else          cyc <= cyc + 1;
  end
  always @(posedge dsr_link_if_inst.miso_oe) oe_seen = 1'b1;
  always @(negedge sys_clk_i) begin
    if (write_unlocked === 1'b1 && unlock_cyc == 0) unlock_cyc = cyc;
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // One whole frame: request, read bytes, then wait for deselect
  task automatic host_req(input logic [7:0] op, input logic [23:0] arg,
                          input logic [1:0] nargs, input logic [7:0] nrd);
    int w;
    oe_seen = 1'b0;
    @(posedge sys_clk_i);
    req_valid <= 1'b1;
    req_op    <= op;
    req_arg   <= arg;
    req_nargs <= nargs;
    req_nrd   <= nrd;
    w = 0;
    do begin @(negedge sys_clk_i); w++; end while (req_ready !== 1'b1 && w < 5000);
    if (w >= 5000) miscompares++;
    @(posedge sys_clk_i);
    req_valid <= 1'b0;
    for (int i = 0; i < nrd; i++) begin
      w = 0;
      do begin @(negedge sys_clk_i); w++; end while (rsp_valid !== 1'b1 && w < 3000);
      rd_q[i] = rsp_data;
      if (w >= 3000) miscompares++;
    end
    w = 0;
    while (dsr_link_if_inst.cs_n !== 1'b0 && w < 10) begin @(negedge sys_clk_i); w++; end
    w = 0;
    while (dsr_link_if_inst.cs_n !== 1'b1 && w < 3000) begin @(negedge sys_clk_i); w++; end
    if (w >= 3000) miscompares++;
    repeat (6) @(negedge sys_clk_i);
  endtask : host_req

  task automatic wait_while(input bit on_busy, input int lim);
    n = 0;
    while ((on_busy ? busy : deep_sleep) === 1'b1 && n < lim) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= lim) miscompares++;
  endtask : wait_while

  task automatic t_power_up;
    `CHK("deep_sleep", 1'b0, deep_sleep)
    `CHK("write_arm", 1'b0, write_arm)
    `CHK("unlocked", 1'b0, write_unlocked)
    host_req(dsr_pkg::OP_READ_STAT, 24'h00_0000, 2'd0, 8'd1);
    `CHK("status", 8'h00, rd_q[0])
    host_req(dsr_pkg::OP_READ_DATA, 24'h00_0100, 2'd3, 8'd2);
    `CHK("array0", dsr_pkg::ERASED_BYTE, rd_q[0])
    `CHK("array1", dsr_pkg::ERASED_BYTE, rd_q[1])
    n = 0;
    while (write_unlocked !== 1'b1 && n < 1000) begin @(negedge sys_clk_i); n++; end
    `CHK("unlock_time", DEV_PUW, unlock_cyc)
    $display("test power_up done");
  endtask : t_power_up

  task automatic t_sig_read;
    host_req(dsr_pkg::OP_WAKE_SIG, 24'h5A_C3_96, 2'd3, 8'd3);
    for (int i = 0; i < 3; i++) `CHK("signature", SIG, rd_q[i])
    `CHK("standby", 1'b0, deep_sleep)
    $display("test sig_read done");
  endtask : t_sig_read

  task automatic t_deep_wake;
    host_req(dsr_pkg::OP_DEEP_SLEEP, 24'h00_0000, 2'd0, 8'd0);
    `CHK("asleep", 1'b1, deep_sleep)
    host_req(dsr_pkg::OP_READ_STAT, 24'h00_0000, 2'd0, 8'd1);
    `CHK("sleep_quiet", 1'b0, oe_seen)
    host_req(dsr_pkg::OP_WRITE_ARM, 24'h00_0000, 2'd0, 8'd0);
    `CHK("sleep_no_arm", 1'b0, write_arm)
    host_req(dsr_pkg::OP_WAKE_SIG, 24'h00_0000, 2'd3, 8'd1);
    `CHK("wake_sig", SIG, rd_q[0])
    `CHK("still_waking", 1'b1, deep_sleep)
    wait_while(1'b0, 500);
    `CHK("woken", 1'b0, deep_sleep)
    `CHK("wake_bound", 1'b1, (n + 10 >= DEV_WAKE && n <= DEV_WAKE + 10))
    host_req(dsr_pkg::OP_DEEP_SLEEP, 24'h00_0000, 2'd0, 8'd0);
    host_req(dsr_pkg::OP_WAKE_SIG, 24'h00_0000, 2'd0, 8'd0);
    wait_while(1'b0, 500);
    `CHK("early_wake", 1'b0, deep_sleep)
    host_req(dsr_pkg::OP_WAKE_SIG, 24'h00_0000, 2'd0, 8'd0);
    `CHK("early_standby", 1'b0, deep_sleep)
    $display("test deep_wake done");
  endtask : t_deep_wake

  task automatic t_write_ops;
    logic [7:0] ops [4];
    logic [1:0] nargs [4];
    logic [7:0] nrd [4];
    ops   = '{dsr_pkg::OP_BLOCK_WIPE, dsr_pkg::OP_CFG_WRITE, dsr_pkg::OP_PAGE_WRITE,
              dsr_pkg::OP_FULL_WIPE};
    nargs = '{2'd3, 2'd1, 2'd3, 2'd0};
    nrd   = '{8'd0, 8'd0, 8'd1, 8'd0};
    for (int k = 0; k < 4; k++) begin
      host_req(dsr_pkg::OP_WRITE_ARM, 24'h00_0000, 2'd0, 8'd0);
      `CHK("armed", 1'b1, write_arm)
      host_req(ops[k], 24'h01_2300, nargs[k], nrd[k]);
      `CHK("busy", 1'b1, busy)
      if (k == 0) begin
        host_req(dsr_pkg::OP_READ_STAT, 24'h00_0000, 2'd0, 8'd1);
        `CHK("busy_status", 8'h03, rd_q[0])
        host_req(dsr_pkg::OP_WAKE_SIG, 24'h00_0000, 2'd3, 8'd1);
        `CHK("busy_no_sig", 1'b0, oe_seen)
        host_req(dsr_pkg::OP_DEEP_SLEEP, 24'h00_0000, 2'd0, 8'd0);
        `CHK("busy_no_sleep", 1'b0, deep_sleep)
        `CHK("busy_kept", 1'b1, busy)
      end
      wait_while(1'b1, DEV_BUSY + 500);
      host_req(dsr_pkg::OP_READ_STAT, 24'h00_0000, 2'd0, 8'd1);
      `CHK("idle_status", 8'h00, rd_q[0])
    end
    $display("test write_ops done");
  endtask : t_write_ops

  task automatic t_reset_again;
    host_req(dsr_pkg::OP_DEEP_SLEEP, 24'h00_0000, 2'd0, 8'd0);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(negedge sys_clk_i);
    `CHK("rst_deep", 1'b0, deep_sleep)
    `CHK("rst_unlock", 1'b0, write_unlocked)
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    host_req(dsr_pkg::OP_READ_STAT, 24'h00_0000, 2'd0, 8'd1);
    `CHK("rst_status", 8'h00, rd_q[0])
    $display("test reset_again done");
  endtask : t_reset_again

  initial begin
    #600000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    rst_n_i = 1'b0;
    req_valid = 1'b0;
    req_op = 8'h00;
    req_arg = 24'h00_0000;
    req_nargs = 2'd0;
    req_nrd = 8'h00;
    miscompares = 0;
    samples_checked = 0;
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(negedge sys_clk_i);
    t_power_up();
    t_sig_read();
    t_deep_wake();
    t_write_ops();
    t_reset_again();
    report_and_stop();
  end
endmodule : deep_sleep_release_signature_bench
